// file: address_shared_io_port.sv
// address_shared_io_port.sv: 8-bit port shared between the low address byte and generic io
// assumes: mode pins are static and valid while srst is high; addr_low comes from the bus
// controller on mclk; pins are resolved outside from pin_out and pin_oe_n (low = driving)
//
// Implementation choice: the strobed register port.
`default_nettype none
`include "address_shared_io_port_defines.svh"

module address_shared_io_port #(
   parameter int PINS      = `PORT_PINS,
   parameter int ADDR_BITS = `BUS_ADDR_BITS
) (
   input  wire logic                              mclk,
   input  wire logic                              srst,
   input  wire address_shared_io_port_pkg::mode_t mode,
   input  wire logic                              hw_standby,
   input  wire logic                              sw_standby,
   input  wire logic [ADDR_BITS-1:0]              bus_addr,
   input  wire logic [PINS-1:0]                   bus_wdata,
   input  wire logic                              bus_wr,
   input  wire logic                              bus_rd,
   output var  logic [PINS-1:0]                   bus_rdata,
   input  wire logic [PINS-1:0]                   addr_low,
   input  wire logic [PINS-1:0]                   pin_in,
   output var  logic [PINS-1:0]                   pin_out,
   output var  logic [PINS-1:0]                   pin_oe_n,
   output var  logic [PINS-1:0]                   addr_drive
);
   import address_shared_io_port_pkg::*;

   // decode on the low address bits only
   function automatic logic hits(input logic [ADDR_BITS-1:0] a,
                                 input logic [`DECODE_BITS-1:0] offs);
      hits = (a[`DECODE_BITS-1:0] == offs);
   endfunction : hits

   function automatic mode_class_e class_of(input mode_t m);
      unique case (m)
         3'h1, 3'h2, 3'h3, 3'h4: class_of = CLASS_ADDRESS;
         `MODE_MIXED:             class_of = CLASS_MIXED;
         `MODE_SINGLE_LOW,
         `MODE_SINGLE_HIGH:       class_of = CLASS_SINGLE;
         // mode code 0 is not a legal strap; fall back to the safest, single-chip
         default:                 class_of = CLASS_SINGLE;
      endcase
   endfunction : class_of

   function automatic pin_role_e role_of(input mode_class_e c, input logic dir_bit);
      unique case (c)
         CLASS_ADDRESS: role_of = ROLE_ADDRESS;
         CLASS_MIXED:   role_of = dir_bit ? ROLE_ADDRESS : ROLE_INPUT;
         CLASS_SINGLE:  role_of = dir_bit ? ROLE_OUTPUT : ROLE_INPUT;
      endcase
   endfunction : role_of

   function automatic logic [PINS-1:0] dir_reset_of(input mode_class_e c);
      dir_reset_of = (c == CLASS_ADDRESS) ? PINS'(`DIR_RESET_EXPANDED) : PINS'(`DIR_RESET_OTHER);
   endfunction : dir_reset_of

   mode_t            mode_q;
   logic [PINS-1:0]  dir;
   logic [PINS-1:0]  latch;
   logic [PINS-1:0]  next_dir;
   logic [PINS-1:0]  next_latch;
   logic [PINS-1:0]  next_rdata;
   logic [PINS-1:0]  next_pin_out;
   logic [PINS-1:0]  next_oe_n;
   logic [PINS-1:0]  next_addr_drive;
   logic [PINS-1:0]  pin_level;

   wire  mode_class_e cls_live;
   wire  mode_class_e cls;
   wire               hit_dir;
   wire               hit_latch;
   wire               wr_dir;
   wire               wr_latch;
   wire               clear_regs;
   wire  [PINS-1:0]   dir_eff;
   wire  [PINS-1:0]   latch_view;

   pin_level_sync #(
      .WIDTH (PINS)
   ) u_sync (
      .mclk  (mclk),
      .srst  (srst),
      .raw   (pin_in),
      .level (pin_level)
   );

   // mode is a strap: taken while srst is high, held afterwards
   always_ff @(posedge mclk) begin
      if (srst) begin
         mode_q <= mode;
      end
   end

   assign cls_live = class_of(mode);
   assign cls      = class_of(mode_q);

   assign hit_dir    = hits(bus_addr, `PIN_DIRECTION_OFFSET);
   assign hit_latch  = hits(bus_addr, `PIN_LATCH_OFFSET);
   assign wr_dir     = bus_wr & hit_dir & (cls != CLASS_ADDRESS);
   assign wr_latch   = bus_wr & hit_latch;
   assign clear_regs = hw_standby;

   // modes 1 to 4 see ones whatever is stored
   assign dir_eff    = (cls == CLASS_ADDRESS) ? PINS'(`DIR_RESET_EXPANDED) : dir;

   // per bit: latch where configured out, live pin where configured in
   assign latch_view = (latch & dir_eff) | (pin_level & ~dir_eff);

   always_comb begin
      next_dir = dir;  // software standby leaves it alone
      if (clear_regs) begin
         next_dir = dir_reset_of(cls);
      end else if (wr_dir) begin
         next_dir = bus_wdata;
      end
   end

   always_comb begin
      next_latch = latch;  // held through software standby
      if (clear_regs) begin
         next_latch = PINS'(`LATCH_RESET);
      end else if (wr_latch) begin
         next_latch = bus_wdata;
      end
   end

   // read data stand only in the cycle after the strobe
   always_comb begin
      next_rdata = PINS'(`UNMAPPED_READ_VALUE);
      if (bus_rd) begin
         if (hit_dir) begin
            next_rdata = PINS'(`DIR_READ_VALUE);
         end else if (hit_latch) begin
            next_rdata = latch_view;
         end
      end
   end

   // pin roles, one per bit
   genvar gi;
   generate
      for (gi = 0; gi < PINS; gi++) begin : g_pin
         wire pin_role_e role;
         assign role = role_of(cls, dir[gi]);
         always_comb begin
            unique case (role)
               ROLE_ADDRESS: begin
                  next_pin_out[gi]    = addr_low[gi];
                  next_oe_n[gi]       = 1'b0;
                  next_addr_drive[gi] = 1'b1;
               end
               ROLE_OUTPUT: begin
                  next_pin_out[gi]    = latch[gi];
                  next_oe_n[gi]       = 1'b0;
                  next_addr_drive[gi] = 1'b0;
               end
               ROLE_INPUT: begin
                  next_pin_out[gi]    = 1'b0;
                  next_oe_n[gi]       = 1'b1;
                  next_addr_drive[gi] = 1'b0;
               end
            endcase
            // the pins float in hardware standby, whatever the role
            if (hw_standby) begin
               next_pin_out[gi]    = 1'b0;
               next_oe_n[gi]       = 1'b1;
               next_addr_drive[gi] = 1'b0;
            end
            // address bits freeze in software standby; the bus is idle then
            if (sw_standby && (role == ROLE_ADDRESS)) begin
               next_pin_out[gi] = pin_out[gi];
            end
         end
      end
   endgenerate

   // reset values use the live strap since mode_q is loading on the same edge
   always_ff @(posedge mclk) begin
      if (srst) begin
         dir   <= dir_reset_of(cls_live);  // inputs in mode 5 until written
         latch <= PINS'(`LATCH_RESET);
      end else begin
         dir   <= next_dir;
         latch <= next_latch;
      end
   end

   always_ff @(posedge mclk) begin
      if (srst) begin
         bus_rdata <= '0;
      end else begin
         bus_rdata <= next_rdata;
      end
   end

   // registered pins cost one cycle of address latency, accepted for glitch-free outputs
   always_ff @(posedge mclk) begin
      if (srst) begin
         pin_out    <= '0;
         pin_oe_n   <= '1;
         addr_drive <= '0;
      end else begin
         pin_out    <= next_pin_out;
         pin_oe_n   <= next_oe_n;
         addr_drive <= next_addr_drive;
      end
   end

endmodule : address_shared_io_port

`default_nettype wire

// file: address_shared_io_port_asserts.sv
// address_shared_io_port_asserts.sv: pin role and read data checks for the shared address/io port
// assumes: mode only changes while srst is high; bound to every instance of the port
`default_nettype none
`include "address_shared_io_port_defines.svh"
module address_shared_io_port_checker (
   input wire logic                              mclk,
   input wire logic                              srst,
   input wire address_shared_io_port_pkg::mode_t mode,
   input wire logic                              hw_standby,
   input wire logic                              sw_standby,
   input wire logic [23:0]                       bus_addr,
   input wire logic [7:0]                        bus_wdata,
   input wire logic                              bus_wr,
   input wire logic                              bus_rd,
   input wire logic [7:0]                        bus_rdata,
   input wire logic [7:0]                        addr_low,
   input wire logic [7:0]                        pin_out,
   input wire logic [7:0]                        pin_oe_n,
   input wire logic [7:0]                        addr_drive
);
   import address_shared_io_port_pkg::*;
   default clocking @(posedge mclk); endclocking
   default disable iff (srst);
   wire logic expanded = mode >= 3'h1 && mode <= 3'h4;
   sequence latch_wr_s;
      bus_wr && bus_addr[19:0] == `PIN_LATCH_OFFSET && mode >= 3'h6 && !hw_standby;
   endsequence
   addr_roles_a: assert property (expanded && !hw_standby && !sw_standby |=>
      addr_drive == 8'hFF && pin_oe_n == 8'h00) else $error("expanded mode pins not all address");
   addr_value_a: assert property (!hw_standby && !sw_standby |=>
      ((pin_out ^ $past(addr_low)) & addr_drive) == 8'h00) else $error("address pin value wrong");
   mixed_roles_a: assert property (mode == 3'h5 && !hw_standby |=> addr_drive == ~pin_oe_n)
      else $error("mode 5 pin is a generic output");
   mixed_reset_a: assert property ($fell(srst) && mode == 3'h5 |->
      pin_oe_n == 8'hFF ##1 pin_oe_n == 8'hFF) else $error("mode 5 pin driven after reset");
   single_roles_a: assert property (mode >= 3'h6 |=> addr_drive == 8'h00)
      else $error("single chip pin carries address");
   latch_out_a: assert property (latch_wr_s ##1 !hw_standby |=>
      ((pin_out ^ $past(bus_wdata, 2)) & ~pin_oe_n) == 8'h00) else $error("output pin not from latch");
   dir_read_a: assert property (bus_rd && bus_addr[19:0] == `PIN_DIRECTION_OFFSET |=>
      bus_rdata == 8'hFF) else $error("direction read not all ones");
   hw_float_a: assert property (hw_standby [*3] |-> pin_oe_n == 8'hFF)
      else $error("pin driven in hardware standby");
endmodule : address_shared_io_port_checker
bind address_shared_io_port address_shared_io_port_checker chk_u (.mclk(mclk), .srst(srst), .mode(mode),
   .hw_standby(hw_standby), .sw_standby(sw_standby), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
   .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata), .addr_low(addr_low), .pin_out(pin_out),
   .pin_oe_n(pin_oe_n), .addr_drive(addr_drive));
`default_nettype wire

// file: address_shared_io_port_defines.svh
// address_shared_io_port_defines.svh: offsets, reset values and widths of the shared address/io port
// assumes: included by bare name from the package and the design modules
`ifndef ADDRESS_SHARED_IO_PORT_DEFINES_SVH
`define ADDRESS_SHARED_IO_PORT_DEFINES_SVH

// register offsets, lower 20 bits of the full address
`define DECODE_BITS            20
`define PIN_DIRECTION_OFFSET   20'hEE000
`define PIN_LATCH_OFFSET       20'hFFFD0

// port geometry
`define PORT_PINS              8
`define BUS_ADDR_BITS          24
`define MODE_BITS              3

// reset values
`define DIR_RESET_EXPANDED     8'hFF
`define DIR_RESET_OTHER        8'h00
`define LATCH_RESET            8'h00

// read answers
`define DIR_READ_VALUE         8'hFF
`define UNMAPPED_READ_VALUE    8'h00

// operating mode codes
`define MODE_FIRST_EXPANDED    3'h1
`define MODE_LAST_EXPANDED     3'h4
`define MODE_MIXED             3'h5
`define MODE_SINGLE_LOW        3'h6
`define MODE_SINGLE_HIGH       3'h7

// pin input synchroniser depth
`define SYNC_STAGES            3

`endif

// file: address_shared_io_port_pkg.sv
// address_shared_io_port_pkg.sv: types shared by the shared address/io port modules
// assumes: the defines header is on the include path
`default_nettype none
`include "address_shared_io_port_defines.svh"

package address_shared_io_port_pkg;

   typedef logic [`MODE_BITS-1:0] mode_t;

   // how the whole port behaves in a given operating mode
   typedef enum logic [1:0] {
      CLASS_ADDRESS,
      CLASS_MIXED,
      CLASS_SINGLE
   } mode_class_e;

   // what one pin does this cycle
   typedef enum logic [1:0] {
      ROLE_ADDRESS,
      ROLE_INPUT,
      ROLE_OUTPUT
   } pin_role_e;

endpackage : address_shared_io_port_pkg

`default_nettype wire

// file: address_shared_io_port_tb.sv
// address_shared_io_port_tb.sv: register and pin scenarios across all operating modes
// assumes: board_side_model closes the pin loop; the checker is bound to the port
`default_nettype none
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin fails++; \
   $display("unexpected %s expected %h seen %h", nm, (e), (g)); end end
module address_shared_io_port_tb;
   timeunit 1ns;
   timeprecision 1ns;
   import address_shared_io_port_pkg::*;
   logic        mclk = 1'b0;
   logic        srst = 1'b1;
   mode_t       mode = 3'h1;
   logic        hw_standby = 1'b0, sw_standby = 1'b0, bus_wr = 1'b0, bus_rd = 1'b0;
   logic [23:0] bus_addr = 24'h000000;
   logic [7:0]  bus_wdata = 8'h00, addr_low = 8'h96, board = 8'h3C;
   logic [7:0]  bus_rdata, pin_in, pin_out, pin_oe_n, addr_drive;
   int          fails = 0, comparisons = 0;
   always #50 mclk = ~mclk;
   address_shared_io_port dut_u (.mclk(mclk), .srst(srst), .mode(mode), .hw_standby(hw_standby),
      .sw_standby(sw_standby), .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd),
      .bus_rdata(bus_rdata), .addr_low(addr_low), .pin_in(pin_in), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
      .addr_drive(addr_drive));
   board_side_model board_u (.board_level(board), .pin_out(pin_out), .pin_oe_n(pin_oe_n), .pin_in(pin_in));
   task automatic cyc(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask : cyc
   task automatic wr(input logic [23:0] a, input logic [7:0] d);
      @(posedge mclk);
      bus_wr <= 1'b1;
      bus_addr <= a;
      bus_wdata <= d;
      @(posedge mclk);
      bus_wr <= 1'b0;
   endtask : wr
   task automatic rd(input logic [23:0] a, input logic [7:0] e);
      @(posedge mclk);
      bus_rd <= 1'b1;
      bus_addr <= a;
      @(posedge mclk);
      bus_rd <= 1'b0;
      #1;
      `CHK("bus_rdata", e, bus_rdata)
   endtask : rd
   // mode moves on the edge that raises srst, so checks never judge a new mode by old outputs
   task automatic rst(input mode_t m);
      @(posedge mclk);
      srst <= 1'b1;
      mode <= m;
      repeat (8) @(posedge mclk);
      srst <= 1'b0;
      cyc(3);
   endtask : rst
   task automatic end_sim;
      if (fails == 0 && comparisons > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : end_sim
   initial begin
      for (int m = 0; m <= 7; m++) begin
         rst(mode_t'(m));
         `CHK("addr_drive", (m >= 1 && m <= 4) ? 8'hFF : 8'h00, addr_drive)
         `CHK("pin_oe_n", (m >= 1 && m <= 4) ? 8'h00 : 8'hFF, pin_oe_n)
         rd(24'h0EE000, 8'hFF);
         rd(24'h0FFFD0, (m >= 1 && m <= 4) ? 8'h00 : 8'h3C);
      end
      rst(3'h1);
      wr(24'h0EE000, 8'h00);
      wr(24'hFFFFD0, 8'hA5);
      addr_low <= 8'h5B;
      cyc(2);
      `CHK("addr_drive", 8'hFF, addr_drive)
      `CHK("pin_out", 8'h5B, pin_out)
      rd(24'h0FFFD0, 8'hA5);
      rd(24'h0FFFD1, 8'h00);
      rst(3'h5);
      wr(24'hAEE000, 8'h0F);
      cyc(2);
      `CHK("addr_drive", 8'h0F, addr_drive)
      `CHK("pin_oe_n", 8'hF0, pin_oe_n)
      `CHK("pin_out", 8'h0B, pin_out & 8'h0F)
      rd(24'h0FFFD0, 8'h30);
      rd(24'h0EE000, 8'hFF);
      rst(3'h6);
      board <= 8'hC3;
      wr(24'h0EE000, 8'hF0);
      wr(24'h0FFFD0, 8'h5A);
      cyc(6);
      `CHK("pin_oe_n", 8'h0F, pin_oe_n)
      `CHK("pin_out", 8'h50, pin_out & 8'hF0)
      rd(24'h0FFFD0, 8'h53);
      sw_standby <= 1'b1;
      cyc(8);
      `CHK("pin_oe_n", 8'h0F, pin_oe_n)
      `CHK("pin_out", 8'h50, pin_out & 8'hF0)
      sw_standby <= 1'b0;
      rd(24'h0FFFD0, 8'h53);
      hw_standby <= 1'b1;
      cyc(4);
      `CHK("pin_oe_n", 8'hFF, pin_oe_n)
      hw_standby <= 1'b0;
      cyc(2);
      `CHK("pin_oe_n", 8'hFF, pin_oe_n)
      rd(24'h0FFFD0, 8'hC3);
      wr(24'h0EE000, 8'hFF);
      rd(24'h0FFFD0, 8'h00);
      end_sim();
   end
   // a hung scenario still reaches the verdict
   initial begin
      #500000;
      fails++;
      end_sim();
   end
endmodule : address_shared_io_port_tb
`default_nettype wire

// file: board_side_model.sv
// board_side_model.sv: board signals on the far side of the shared port pins
// assumes: the board holds a steady level on every pin that the port releases
`default_nettype none
module board_side_model (
   input  wire logic [7:0] board_level,
   input  wire logic [7:0] pin_out,
   input  wire logic [7:0] pin_oe_n,
   output var  logic [7:0] pin_in
);
   // a driven pin reads back the port's own value, a released one the board's
   assign pin_in = (pin_out & ~pin_oe_n) | (board_level & pin_oe_n);
endmodule : board_side_model
`default_nettype wire

// file: pin_level_sync.sv
// pin_level_sync.sv: three-stage synchroniser with agreement filter for the port pins
// assumes: pins change asynchronously to mclk; one bit of output per pin
`default_nettype none
`include "address_shared_io_port_defines.svh"

module pin_level_sync #(
   parameter int WIDTH = `PORT_PINS
) (
   input  wire logic             mclk,
   input  wire logic             srst,
   input  wire logic [WIDTH-1:0] raw,
   output var  logic [WIDTH-1:0] level
);

   logic [WIDTH-1:0] stage1;
   logic [WIDTH-1:0] stage2;
   logic [WIDTH-1:0] stage3;
   wire  [WIDTH-1:0] agree;

   // stage1 feeds stage2 only; the filter looks at stages 2 and 3
   assign agree = ~(stage2 ^ stage3);

   always_ff @(posedge mclk) begin
      stage1 <= raw;
      stage2 <= stage1;
      stage3 <= stage2;
   end

   always_ff @(posedge mclk) begin
      if (srst) begin
         level <= '0;
      end else begin
         level <= (level & ~agree) | (stage3 & agree);
      end
   end

endmodule : pin_level_sync

`default_nettype wire
